// ===== design/link_autoneg_crossover.sv
/*
 * link establishment for a triple-speed twisted-pair transceiver:
 * negotiation, parallel detection, master/slave, forced modes, pair
 * crossover, pair deskew and polarity correction, plus management registers.
 * assumes pages, pulses and link health arrive already decoded from the
 * receive front end, synchronous to the 250 MHz core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module link_autoneg_crossover #(
	parameter int BURST_CYC = link_pkg::TX_BURST_CYC,
	parameter int PD_WAIT_CYC = link_pkg::PD_WAIT_CYC,
	parameter int LOSS_CYC = link_pkg::LINK_LOSS_CYC,
	// seed default is arbitrary
	parameter logic [10:0] LOCAL_SEED = 11'h2A5,
	parameter int SYM_W = 3,
	parameter int SEL_W = $clog2(link_pkg::SKEW_SYMS)
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// management registers
	input wire logic [4:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// partner signalling, decoded
	input wire logic rx_page_valid_in,
	input wire logic [15:0] rx_page_in,
	input wire logic rx_nlp_in,
	input wire logic rx_idle100_in,
	input wire logic link_ok_in,
	input wire logic mdix_sense_in,
	input wire logic [3:0] pol_rev_in,
	// pages to transmit
	output logic tx_page_strobe_out,
	output logic [15:0] tx_page_out,
	// resolved operation
	output logic link_up_out,
	output logic [1:0] speed_out,
	output logic full_duplex_out,
	output logic master_out,
	output logic mdix_out,
	output logic [7:0] pair_map_out,
	output logic cd_active_out,
	output logic [3:0] pol_fix_out,
	// gigabit symbol lanes
	input wire logic [4*SYM_W-1:0] sym_in,
	input wire logic [4*SEL_W-1:0] skew_in,
	output logic [4*SYM_W-1:0] sym_out
);

	// ************************************************************
	// state
	// ************************************************************
	link_pkg::an_state_t state_r;
	logic [15:0] ctrl_r, adv_r, msc_r, xo_r;
	logic [15:0] lp_base_r, lp_np_r, lp_msc_r;
	logic [15:0] adv_act_r, msc_act_r;
	logic [3:0] mss_r;
	logic exp_page_r, lp_an_r, an_done_r;
	logic [1:0] np_idx_r, pd_speed_r;
	logic burst_go_r, pd_go_r, loss_go_r, loss_clr_r;
	logic burst_exp, pd_exp, loss_exp, loss_busy;
	logic wr_ctrl, restart, new_an, new_dup;
	logic [1:0] new_spd;
	logic [15:0] np_page, lp_src, rd_mux;
	logic res_ok, res_dup, res_master, res_fault;
	logic [1:0] res_spd;
	logic pd_sig;

	// ************************************************************
	// control register decode
	// ************************************************************
	always_comb begin
		wr_ctrl = reg_wr_in && (reg_addr_in == link_pkg::REG_CTRL);
		new_an = wr_ctrl ? reg_wdata_in[link_pkg::CTRL_AN_EN] : ctrl_r[link_pkg::CTRL_AN_EN];
		new_dup = wr_ctrl ? reg_wdata_in[link_pkg::CTRL_DUP] : ctrl_r[link_pkg::CTRL_DUP];
		new_spd = wr_ctrl ? {reg_wdata_in[link_pkg::CTRL_SPD_MSB],
			reg_wdata_in[link_pkg::CTRL_SPD_LSB]} :
			{ctrl_r[link_pkg::CTRL_SPD_MSB], ctrl_r[link_pkg::CTRL_SPD_LSB]};
		// speed or enable change forces a fresh start, same as bit 9
		restart = wr_ctrl && (reg_wdata_in[link_pkg::CTRL_RESTART] ||
			(new_spd != {ctrl_r[link_pkg::CTRL_SPD_MSB],
			ctrl_r[link_pkg::CTRL_SPD_LSB]}) ||
			(new_an != ctrl_r[link_pkg::CTRL_AN_EN]));
	end

	// ************************************************************
	// management registers
	// ************************************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_r <= link_pkg::CTRL_RST;
			adv_r <= link_pkg::ADV_RST;
			msc_r <= link_pkg::MSC_RST;
			xo_r <= link_pkg::XO_RST;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				link_pkg::REG_CTRL: begin
					ctrl_r <= reg_wdata_in & ~(16'h0001 << link_pkg::CTRL_RESTART);
				end
				link_pkg::REG_ADV: begin
					adv_r <= reg_wdata_in;
				end
				link_pkg::REG_MS_CTRL: begin
					msc_r <= reg_wdata_in;
				end
				link_pkg::REG_XOVER: begin
					xo_r <= reg_wdata_in & 16'h00F0;
				end
				default: begin
				end
			endcase
		end
	end

	// page-received flag: a new page in the same cycle as a read survives
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			exp_page_r <= 1'b0;
		end else if (rx_page_valid_in && (state_r == link_pkg::ST_ABILITY ||
			state_r == link_pkg::ST_NPAGE)) begin
			exp_page_r <= 1'b1;
		end else if (reg_rd_in && reg_addr_in == link_pkg::REG_EXPN) begin
			exp_page_r <= 1'b0;
		end
	end

	always_comb begin
		rd_mux = 16'h0000;
		case (reg_addr_in)
			link_pkg::REG_CTRL: rd_mux = ctrl_r;
			link_pkg::REG_STAT: begin
				rd_mux[link_pkg::STAT_LINK] = link_up_out;
				rd_mux[link_pkg::STAT_AN_ABLE] = 1'b1;
				rd_mux[link_pkg::STAT_AN_DONE] = an_done_r;
			end
			link_pkg::REG_ADV: rd_mux = adv_r;
			link_pkg::REG_LP_BASE: rd_mux = lp_base_r;
			link_pkg::REG_EXPN: begin
				rd_mux[link_pkg::EXP_LP_AN] = lp_an_r;
				rd_mux[link_pkg::EXP_PAGE] = exp_page_r;
			end
			link_pkg::REG_LP_NP: rd_mux = lp_np_r;
			link_pkg::REG_MS_CTRL: rd_mux = msc_r;
			link_pkg::REG_MS_STAT: rd_mux = {mss_r[3:2], 2'h0, mss_r[1:0], 10'h000};
			link_pkg::REG_XOVER: begin
				rd_mux = xo_r;
				rd_mux[link_pkg::XO_MDIX] = mdix_out;
				rd_mux[link_pkg::XO_AUTO] = ~xo_r[link_pkg::XO_OFF];
			end
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rd_mux;
		end
	end

	// ************************************************************
	// interval timers, all counted on the fixed core clock
	// ************************************************************
	interval_timer #(.CNT_W(link_pkg::TMR_W)) u_burst_tmr (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.start_in(burst_go_r),
		.clear_in(1'b0),
		.load_in(link_pkg::TMR_W'(BURST_CYC)),
		.busy_out(),
		.expired_out(burst_exp)
	);

	interval_timer #(.CNT_W(link_pkg::TMR_W)) u_pd_tmr (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.start_in(pd_go_r),
		.clear_in(1'b0),
		.load_in(link_pkg::TMR_W'(PD_WAIT_CYC)),
		.busy_out(),
		.expired_out(pd_exp)
	);

	interval_timer #(.CNT_W(link_pkg::TMR_W)) u_loss_tmr (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.start_in(loss_go_r),
		.clear_in(loss_clr_r),
		.load_in(link_pkg::TMR_W'(LOSS_CYC)),
		.busy_out(loss_busy),
		.expired_out(loss_exp)
	);

	// ************************************************************
	// page content and mode resolution
	// ************************************************************
	always_comb begin
		case (np_idx_r)
			2'h0: np_page = {1'b1, 1'b0, 1'b1, 2'h0, link_pkg::GIG_MSG_CODE};
			2'h1: np_page = {1'b1, 1'b0, 1'b0, msc_act_r[12:0]};
			default: np_page = {3'h0, 2'h0, LOCAL_SEED};
		endcase
	end

	always_comb begin
		lp_src = (state_r == link_pkg::ST_ABILITY) ? rx_page_in : lp_base_r;
		pd_sig = (pd_speed_r == link_pkg::SPD_100) ? rx_idle100_in : rx_nlp_in;
		res_ok = 1'b1;
		res_spd = link_pkg::SPD_10;
		res_dup = 1'b0;
		res_fault = 1'b0;
		res_master = 1'b0;
		// master/slave is settled before the gigabit mode is allowed
		if (msc_act_r[link_pkg::MSC_MS_MAN] && lp_msc_r[link_pkg::MSC_MS_MAN]) begin
			res_master = msc_act_r[link_pkg::MSC_MS_VAL];
			res_fault = msc_act_r[link_pkg::MSC_MS_VAL] == lp_msc_r[link_pkg::MSC_MS_VAL];
		end else if (msc_act_r[link_pkg::MSC_MS_MAN]) begin
			res_master = msc_act_r[link_pkg::MSC_MS_VAL];
		end else if (lp_msc_r[link_pkg::MSC_MS_MAN]) begin
			res_master = ~lp_msc_r[link_pkg::MSC_MS_VAL];
		end else begin
			res_master = LOCAL_SEED > rx_page_in[10:0];
			res_fault = LOCAL_SEED == rx_page_in[10:0];
		end
		// gigabit half is never chosen: the device cannot run it
		if (state_r == link_pkg::ST_NPAGE && !res_fault &&
			msc_act_r[link_pkg::MSC_1000FD] && lp_msc_r[link_pkg::MSC_1000FD]) begin
			res_spd = link_pkg::SPD_1000;
			res_dup = 1'b1;
		end else if (adv_act_r[link_pkg::ADV_100FD] && lp_src[link_pkg::ADV_100FD]) begin
			res_spd = link_pkg::SPD_100;
			res_dup = 1'b1;
		end else if (adv_act_r[link_pkg::ADV_100HD] && lp_src[link_pkg::ADV_100HD]) begin
			res_spd = link_pkg::SPD_100;
		end else if (adv_act_r[link_pkg::ADV_10FD] && lp_src[link_pkg::ADV_10FD]) begin
			res_dup = 1'b1;
		end else if (!(adv_act_r[link_pkg::ADV_10HD] && lp_src[link_pkg::ADV_10HD])) begin
			res_ok = 1'b0;
		end
	end

	// ************************************************************
	// negotiation sequencer
	// ************************************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= link_pkg::ST_ABILITY;
			np_idx_r <= 2'h0;
			burst_go_r <= 1'b1;
			pd_go_r <= 1'b0;
			loss_go_r <= 1'b0;
			loss_clr_r <= 1'b0;
			tx_page_strobe_out <= 1'b0;
			tx_page_out <= 16'h0000;
			link_up_out <= 1'b0;
			an_done_r <= 1'b0;
			speed_out <= link_pkg::SPD_10;
			full_duplex_out <= 1'b0;
			master_out <= 1'b0;
			pd_speed_r <= link_pkg::SPD_10;
			adv_act_r <= link_pkg::ADV_RST;
			msc_act_r <= link_pkg::MSC_RST;
			lp_base_r <= 16'h0000;
			lp_np_r <= 16'h0000;
			lp_msc_r <= 16'h0000;
			lp_an_r <= 1'b0;
			mss_r <= 4'h0;
		end else begin
			burst_go_r <= 1'b0;
			pd_go_r <= 1'b0;
			loss_go_r <= 1'b0;
			loss_clr_r <= 1'b0;
			tx_page_strobe_out <= 1'b0;
			if (restart) begin
				link_up_out <= 1'b0;
				an_done_r <= 1'b0;
				adv_act_r <= adv_r;
				msc_act_r <= msc_r;
				np_idx_r <= 2'h0;
				loss_clr_r <= 1'b1;
				if (new_an) begin
					state_r <= link_pkg::ST_ABILITY;
					burst_go_r <= 1'b1;
				end else begin
					state_r <= link_pkg::ST_FORCED;
					speed_out <= new_spd;
					full_duplex_out <= new_dup;
				end
			end else begin
				case (state_r)
					link_pkg::ST_ABILITY, link_pkg::ST_NPAGE: begin
						if (burst_exp) begin
							tx_page_out <= (state_r == link_pkg::ST_ABILITY) ? adv_act_r : np_page;
							tx_page_strobe_out <= 1'b1;
							burst_go_r <= 1'b1;
						end
						if (rx_page_valid_in && state_r == link_pkg::ST_ABILITY) begin
							lp_base_r <= rx_page_in;
							lp_an_r <= 1'b1;
							if (adv_act_r[link_pkg::ADV_NP] && rx_page_in[link_pkg::ADV_NP]) begin
								state_r <= link_pkg::ST_NPAGE;
								np_idx_r <= 2'h0;
							end else if (res_ok) begin
								state_r <= link_pkg::ST_LINKED;
								link_up_out <= 1'b1;
								an_done_r <= 1'b1;
								speed_out <= res_spd;
								full_duplex_out <= res_dup;
							end
						end else if (rx_page_valid_in) begin
							lp_np_r <= rx_page_in;
							np_idx_r <= np_idx_r + 2'h1;
							if (np_idx_r == 2'h1) begin
								lp_msc_r <= rx_page_in;
							end
							if (np_idx_r == link_pkg::GIG_LAST_PAGE) begin
								np_idx_r <= 2'h0;
								mss_r <= {res_fault, res_master,
									lp_msc_r[link_pkg::MSC_1000FD], lp_msc_r[link_pkg::MSC_1000HD]};
								if (res_ok) begin
									state_r <= link_pkg::ST_LINKED;
									link_up_out <= 1'b1;
									an_done_r <= 1'b1;
									speed_out <= res_spd;
									full_duplex_out <= res_dup;
									master_out <= res_master;
								end else begin
									state_r <= link_pkg::ST_ABILITY;
								end
							end
						end else if (state_r == link_pkg::ST_ABILITY &&
							(rx_nlp_in || rx_idle100_in)) begin
							// only 10/100 signalling can be detected here
							state_r <= link_pkg::ST_PDWAIT;
							pd_speed_r <= rx_idle100_in ? link_pkg::SPD_100 : link_pkg::SPD_10;
							pd_go_r <= 1'b1;
						end
					end
					link_pkg::ST_PDWAIT: begin
						if (!pd_sig) begin
							state_r <= link_pkg::ST_ABILITY;
							burst_go_r <= 1'b1;
						end else if (pd_exp) begin
							state_r <= link_pkg::ST_LINKED;
							link_up_out <= 1'b1;
							lp_an_r <= 1'b0;
							speed_out <= pd_speed_r;
							full_duplex_out <= (pd_speed_r == link_pkg::SPD_100) ?
								xo_r[link_pkg::XO_PD100FD] : xo_r[link_pkg::XO_PD10FD];
						end
					end
					link_pkg::ST_LINKED: begin
						if (link_ok_in) begin
							loss_clr_r <= loss_busy;
						end else if (!loss_busy && !loss_go_r) begin
							loss_go_r <= 1'b1;
						end
						if (loss_exp && !link_ok_in) begin
							// link down: pending ability edits now take effect
							state_r <= link_pkg::ST_ABILITY;
							link_up_out <= 1'b0;
							an_done_r <= 1'b0;
							adv_act_r <= adv_r;
							msc_act_r <= msc_r;
							burst_go_r <= 1'b1;
						end
					end
					link_pkg::ST_FORCED: begin
						link_up_out <= link_ok_in;
					end
					default: begin
						state_r <= link_pkg::ST_ABILITY;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// pair crossover and polarity
	// ************************************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mdix_out <= 1'b0;
		end else if (xo_r[link_pkg::XO_OFF]) begin
			mdix_out <= xo_r[link_pkg::XO_MAN];
		end else if (!link_up_out) begin
			// mapping is frozen once the link is up to avoid flapping
			mdix_out <= mdix_sense_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pair_map_out <= link_pkg::MAP_MDI;
			cd_active_out <= 1'b0;
			pol_fix_out <= 4'h0;
		end else begin
			pair_map_out <= mdix_out ? link_pkg::MAP_MDIX : link_pkg::MAP_MDI;
			cd_active_out <= link_up_out && speed_out == link_pkg::SPD_1000;
			pol_fix_out <= (speed_out == link_pkg::SPD_100) ? 4'h0 : pol_rev_in;
		end
	end

	pair_deskew #(.SYM_W(SYM_W), .DEPTH(link_pkg::SKEW_SYMS), .SEL_W(SEL_W)) u_deskew (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.sym_in(sym_in),
		.skew_in(skew_in),
		.inv_in(pol_fix_out),
		.sym_out(sym_out)
	);

endmodule
`default_nettype wire

// ===== design/link_pkg.sv
/*
 * shared constants of the link establishment block: register map, field
 * positions, reset values, interval timer lengths, mode and state types.
 * assumes a 250 MHz core clock synthesised from the 25 MHz reference.
 */
package link_pkg;

	// ************************************************************
	// register map (management register numbers)
	// ************************************************************
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h01;
	localparam logic [4:0] REG_ADV = 5'h04;
	localparam logic [4:0] REG_LP_BASE = 5'h05;
	localparam logic [4:0] REG_EXPN = 5'h06;
	localparam logic [4:0] REG_LP_NP = 5'h08;
	localparam logic [4:0] REG_MS_CTRL = 5'h09;
	localparam logic [4:0] REG_MS_STAT = 5'h0A;
	localparam logic [4:0] REG_XOVER = 5'h1C;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_SPD_LSB = 13;
	localparam int CTRL_SPD_MSB = 6;
	localparam int CTRL_DUP = 8;
	localparam int CTRL_RESTART = 9;
	localparam int CTRL_AN_EN = 12;
	localparam int STAT_LINK = 2;
	localparam int STAT_AN_ABLE = 3;
	localparam int STAT_AN_DONE = 5;
	localparam int ADV_10HD = 5;
	localparam int ADV_10FD = 6;
	localparam int ADV_100HD = 7;
	localparam int ADV_100FD = 8;
	localparam int ADV_NP = 15;
	localparam int NP_MSG = 13;
	localparam int MSC_1000HD = 8;
	localparam int MSC_1000FD = 9;
	localparam int MSC_MS_VAL = 11;
	localparam int MSC_MS_MAN = 12;
	localparam int MSS_FAULT = 15;
	localparam int MSS_MASTER = 14;
	localparam int MSS_LP_FD = 11;
	localparam int MSS_LP_HD = 10;
	localparam int EXP_LP_AN = 0;
	localparam int EXP_PAGE = 1;
	localparam int XO_MDIX = 0;
	localparam int XO_AUTO = 1;
	localparam int XO_PD100FD = 4;
	localparam int XO_PD10FD = 5;
	localparam int XO_OFF = 6;
	localparam int XO_MAN = 7;

	// ************************************************************
	// reset values and fixed codes
	// ************************************************************
	localparam logic [15:0] CTRL_RST = 16'h1140;
	localparam logic [15:0] ADV_RST = 16'h81E1;
	localparam logic [15:0] MSC_RST = 16'h0200;
	localparam logic [15:0] XO_RST = 16'h0000;
	localparam logic [10:0] GIG_MSG_CODE = 11'h008;
	localparam logic [1:0] GIG_LAST_PAGE = 2'h2;
	// logical pair per pin, D..A, two bits each
	localparam logic [7:0] MAP_MDI = 8'hE4;
	localparam logic [7:0] MAP_MDIX = 8'hB1;

	// ************************************************************
	// interval timers
	// ************************************************************
	localparam int CLK_MHZ = 250;
	localparam int TX_BURST_US = 16000;
	localparam int PD_WAIT_US = 830000;
	localparam int LINK_LOSS_US = 52000;
	localparam int TX_BURST_CYC = TX_BURST_US * CLK_MHZ;
	localparam int PD_WAIT_CYC = PD_WAIT_US * CLK_MHZ;
	localparam int LINK_LOSS_CYC = LINK_LOSS_US * CLK_MHZ;
	localparam int TMR_W = 28;

	// ************************************************************
	// pair skew tolerance, in gigabit symbols
	// ************************************************************
	localparam int SKEW_NS = 60;
	localparam int SYM_NS = 8;
	localparam int SKEW_SYMS = (SKEW_NS + SYM_NS - 1) / SYM_NS;

	typedef enum logic [1:0] {
		SPD_10 = 2'h0,
		SPD_100 = 2'h1,
		SPD_1000 = 2'h2
	} speed_t;

	typedef enum logic [4:0] {
		ST_FORCED = 5'h01,
		ST_ABILITY = 5'h02,
		ST_NPAGE = 5'h04,
		ST_PDWAIT = 5'h08,
		ST_LINKED = 5'h10
	} an_state_t;

endpackage

// ===== design/interval_timer.sv
/*
 * one-shot down counter for the negotiation interval timers.
 * assumes start and clear are single-cycle requests; start wins.
 */
`timescale 1ns/1ns
`default_nettype none
module interval_timer #(
	parameter int CNT_W = link_pkg::TMR_W
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// control
	input wire logic start_in,
	input wire logic clear_in,
	input wire logic [CNT_W-1:0] load_in,
	// status
	output logic busy_out,
	output logic expired_out
);

	logic [CNT_W-1:0] cnt_r;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= '0;
			busy_out <= 1'b0;
			expired_out <= 1'b0;
		end else begin
			expired_out <= 1'b0;
			if (start_in) begin
				cnt_r <= load_in;
				busy_out <= 1'b1;
			end else if (clear_in) begin
				busy_out <= 1'b0;
			end else if (busy_out) begin
				if (cnt_r <= CNT_W'(1)) begin
					busy_out <= 1'b0;
					expired_out <= 1'b1;
				end else begin
					cnt_r <= cnt_r - CNT_W'(1);
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== design/pair_deskew.sv
/*
 * four-lane gigabit symbol delay line: each lane is held back by its own
 * skew count so that all four leave aligned, then optionally negated.
 * assumes the receive path supplies per-lane skew, early lanes largest.
 */
`timescale 1ns/1ns
`default_nettype none
module pair_deskew #(
	parameter int SYM_W = 3,
	parameter int DEPTH = link_pkg::SKEW_SYMS,
	parameter int SEL_W = $clog2(DEPTH)
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// lanes in
	input wire logic [4*SYM_W-1:0] sym_in,
	input wire logic [4*SEL_W-1:0] skew_in,
	input wire logic [3:0] inv_in,
	// lanes out
	output logic [4*SYM_W-1:0] sym_out
);

	for (genvar l = 0; l < 4; l++) begin : g_lane
		logic [SYM_W-1:0] pipe_r [DEPTH];
		logic [SYM_W-1:0] tap;

		assign tap = pipe_r[skew_in[l*SEL_W +: SEL_W]];

		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				for (int i = 0; i < DEPTH; i++) begin
					pipe_r[i] <= '0;
				end
			end else begin
				pipe_r[0] <= sym_in[l*SYM_W +: SYM_W];
				for (int i = 1; i < DEPTH; i++) begin
					pipe_r[i] <= pipe_r[i-1];
				end
			end
		end

		// pam5 symbols are two's complement, so reversed wiring is a negation
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				sym_out[l*SYM_W +: SYM_W] <= '0;
			end else begin
				sym_out[l*SYM_W +: SYM_W] <= inv_in[l] ? -tap : tap;
			end
		end
	end

endmodule
`default_nettype wire

// ===== test/link_partner.sv
/* far end model: sends pages and holds line levels. assumes the bench calls send. */
`timescale 1ns/1ns
`default_nettype none
module link_partner (
	input wire logic clk_in,
	input wire logic tx_strobe_in,
	output logic page_valid_out,
	output logic [15:0] page_out,
	output logic idle100_out,
	output logic mdix_out
);
	initial begin
		page_valid_out = 1'h0;
		page_out = 16'h0;
		idle100_out = 1'h0;
		mdix_out = 1'h0;
	end
	// answer only after a burst of ours, as a real partner would
	task automatic send(input logic [15:0] pages [4]);
		@(posedge tx_strobe_in);
		foreach (pages[i]) begin
			@(negedge clk_in);
			page_valid_out = 1'h1;
			page_out = pages[i];
		end
		@(negedge clk_in);
		page_valid_out = 1'h0;
		page_out = ~page_out;
	endtask
endmodule
`default_nettype wire

// ===== test/link_autoneg_crossover_chk.sv
/* port relations of the link block. assumes bind onto its top module. */
`timescale 1ns/1ns
`default_nettype none
module link_autoneg_crossover_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [4:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic rx_idle100_in,
	input wire logic [3:0] pol_rev_in,
	input wire logic tx_page_strobe_out,
	input wire logic link_up_out,
	input wire logic [1:0] speed_out,
	input wire logic mdix_out,
	input wire logic [7:0] pair_map_out,
	input wire logic cd_active_out,
	input wire logic [3:0] pol_fix_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_map_straight: assert property (
		!$past(mdix_out) |-> pair_map_out == link_pkg::MAP_MDI)
		else $error("straight map wrong");
	a_map_crossed: assert property (
		$past(mdix_out) |-> pair_map_out == link_pkg::MAP_MDIX)
		else $error("crossed map wrong");
	a_cd_gig: assert property (
		cd_active_out == ($past(link_up_out) && $past(speed_out) == 2'h2))
		else $error("pair use wrong");
	a_pol_hundred: assert property (
		speed_out == 2'h1 && $past(speed_out) == 2'h1 |-> pol_fix_out == 4'h0)
		else $error("polarity fixed at 100");
	a_pol_track: assert property (
		!$past(rst_in) && speed_out != 2'h1 && $past(speed_out) != 2'h1
		|-> pol_fix_out == $past(pol_rev_in)) else $error("polarity not tracked");
	a_no_gig_pd: assert property (
		$rose(link_up_out) && $past(rx_idle100_in) |-> speed_out != 2'h2)
		else $error("gigabit from detection");
	a_restart_drop: assert property (
		reg_wr_in && reg_addr_in == 5'h00 && reg_wdata_in[9] |=> !link_up_out)
		else $error("link kept on restart");
	a_strobe_pulse: assert property (
		tx_page_strobe_out |=> !tx_page_strobe_out) else $error("strobe too long");
endmodule
bind link_autoneg_crossover link_autoneg_crossover_chk chk (.clk_in, .rst_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .rx_idle100_in, .pol_rev_in, .tx_page_strobe_out, .link_up_out,
	.speed_out, .mdix_out, .pair_map_out, .cd_active_out, .pol_fix_out);
`default_nettype wire

// ===== test/link_autoneg_crossover_tb.sv
/* bench for the link block. assumes the partner model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module link_autoneg_crossover_tb;
	logic clk_in, rst_in, reg_wr_in, reg_rd_in, rx_nlp_in, link_ok_in, rx_page_valid_in;
	logic rx_idle100_in, mdix_sense_in, tx_page_strobe_out, link_up_out, full_duplex_out;
	logic master_out, mdix_out, cd_active_out;
	logic [1:0] speed_out;
	logic [4:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, rx_page_in, tx_page_out, v;
	logic [7:0] pair_map_out;
	logic [3:0] pol_rev_in, pol_fix_out;
	logic [11:0] sym_in, skew_in, sym_out;
	logic [15:0] pg [4];
	logic [11:0] hist [8], sym_exp, s_nxt;
	logic sym_on = 1'h0;
	int n_errors = 0, n_compared = 0, seed = 32'hCA46, n;
	link_autoneg_crossover #(.BURST_CYC(40), .PD_WAIT_CYC(60), .LOSS_CYC(30)) dut (.clk_in,
		.rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
		.rx_page_valid_in, .rx_page_in, .rx_nlp_in, .rx_idle100_in, .link_ok_in, .mdix_sense_in,
		.pol_rev_in, .tx_page_strobe_out, .tx_page_out, .link_up_out, .speed_out,
		.full_duplex_out, .master_out, .mdix_out, .pair_map_out, .cd_active_out, .pol_fix_out,
		.sym_in, .skew_in, .sym_out);
	link_partner lp (.clk_in, .tx_strobe_in(tx_page_strobe_out), .page_valid_out(rx_page_valid_in),
		.page_out(rx_page_in), .idle100_out(rx_idle100_in), .mdix_out(mdix_sense_in));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'h1;
		@(negedge clk_in);
		reg_wr_in = 1'h0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'h1;
		@(negedge clk_in);
		reg_rd_in = 1'h0;
		@(negedge clk_in);
		v = reg_rdata_out;
	endtask
	// bounded wait for link up
	task automatic waitup;
		for (n = 0; link_up_out !== 1'h1 && n < 300; n++) @(negedge clk_in);
	endtask
	// bounded wait for the next page strobe, n counts cycles
	task automatic waitstb;
		@(negedge clk_in);
		for (n = 1; tx_page_strobe_out !== 1'h1 && n < 100; n++) @(negedge clk_in);
	endtask
	task summarize;
		if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk_in = 1'h0;
		forever #2 clk_in = ~clk_in;
	end
	// lane model: history of sampled symbols, expected lanes for the next edge
	always @(negedge clk_in) begin
		if (sym_on) chk(16'(sym_out), 16'(sym_exp));
		for (int k = 7; k > 0; k--) hist[k] = hist[k-1];
		hist[0] = sym_in;
		s_nxt = 12'($random(seed));
		for (int l = 0; l < 4; l++) begin
			sym_exp[3*l +: 3] = hist[s_nxt[3*l +: 3]][3*l +: 3];
			if (pol_fix_out[l]) sym_exp[3*l +: 3] = -sym_exp[3*l +: 3];
		end
		pol_rev_in <= 4'($random(seed));
		sym_in <= 12'($random(seed));
		skew_in <= s_nxt;
	end
	initial begin
		#40000;
		n_errors++;
		summarize;
	end
	initial begin
		{rst_in, link_ok_in, reg_wr_in, reg_rd_in, rx_nlp_in} = 5'h18;
		{reg_addr_in, reg_wdata_in, pol_rev_in, sym_in, skew_in} = '0;
		repeat (16) @(negedge clk_in);
		rst_in = 1'h0;
		rd(5'h00); chk(v, link_pkg::CTRL_RST);
		rd(5'h04); chk(v, link_pkg::ADV_RST);
		rd(5'h09); chk(v, link_pkg::MSC_RST);
		rd(5'h1F); chk(v, 16'h0);
		wr(5'h1C, 16'h00C0); repeat (3) @(negedge clk_in);
		chk(16'(pair_map_out), 16'(link_pkg::MAP_MDIX));
		rd(5'h1C); chk(v & 16'h0003, 16'h0001);
		wr(5'h1C, 16'h0000); lp.mdix_out = 1'h1; repeat (3) @(negedge clk_in);
		chk(16'(pair_map_out), 16'(link_pkg::MAP_MDIX));
		lp.mdix_out = 1'h0; repeat (3) @(negedge clk_in);
		chk(16'(pair_map_out), 16'(link_pkg::MAP_MDI));
		waitstb; waitstb; chk(16'(n >= 40 && n <= 44), 16'h1);
		pg = '{16'h8181, 16'hA008, 16'h8200, 16'h0123}; // no gigabit half offered
		lp.send(pg); chk(tx_page_out, link_pkg::ADV_RST);
		waitup;
		chk(16'({link_up_out, speed_out, full_duplex_out, master_out}), 16'h1B);
		rd(5'h01); chk(v & 16'h0004, 16'h0004);
		rd(5'h05); chk(v, pg[0]);
		rd(5'h0A); chk(v & 16'hC800, 16'h4800);
		rd(5'h06); chk(v & 16'h0003, 16'h0003);
		rd(5'h06); chk(v & 16'h0003, 16'h0001);
		rd(5'h08); chk(v, pg[3]);
		wr(5'h00, link_pkg::CTRL_RST | 16'h0200); chk(16'(link_up_out), 16'h0);
		lp.idle100_out = 1'h1; waitup; chk(16'(n >= 58), 16'h1);
		chk(16'({speed_out, full_duplex_out}), 16'h2);
		lp.idle100_out = 1'h0; wr(5'h1C, 16'h0020); wr(5'h00, 16'h1340);
		rx_nlp_in = 1'h1; waitup;
		chk(16'({speed_out, full_duplex_out}), 16'h1);
		rx_nlp_in = 1'h0; wr(5'h00, 16'h0100); waitup;
		chk(16'({speed_out, full_duplex_out}), 16'h1);
		sym_on = 1'h1; repeat (2) @(negedge clk_in);
		repeat (8) begin
			@(negedge clk_in); chk(16'(pol_fix_out), 16'(pol_rev_in));
		end
		summarize;
	end
endmodule
`default_nettype wire
